// >>> logic/astr_pkg.sv
package astr_pkg;

	// ****************************************
	// Timing
	// ****************************************
	localparam int unsigned CLK_HZ     = 40_000_000;
	localparam int unsigned DEF_BAUD   = 9600;
	localparam int unsigned OVERSAMPLE = 16;
	localparam logic [15:0] BAUD_DIV_RST = 16'(CLK_HZ / (OVERSAMPLE * DEF_BAUD) - 1);

	// ****************************************
	// Character framing
	// ****************************************
	localparam logic [3:0] FRAME8      = 4'ha;
	localparam logic [3:0] FRAME9      = 4'hb;
	localparam logic [3:0] SUB_LAST    = 4'hf;
	localparam logic [3:0] SMP_FIRST   = 4'h7;
	localparam logic [3:0] SMP_MID     = 4'h8;
	localparam logic [3:0] SMP_LAST    = 4'h9;
	localparam logic [3:0] SMP_DECIDE  = 4'ha;
	localparam logic [7:0] QUIET_TICK8 = 8'(10 * OVERSAMPLE);
	localparam logic [7:0] QUIET_TICK9 = 8'(11 * OVERSAMPLE);

	// ****************************************
	// Register map (byte addresses)
	// ****************************************
	localparam int unsigned ADDR_W = 5;
	localparam logic [4:0] OFS_DATA  = 5'h00;
	localparam logic [4:0] OFS_CTL1  = 5'h04;
	localparam logic [4:0] OFS_CTL2  = 5'h08;
	localparam logic [4:0] OFS_FLAGS = 5'h0c;
	localparam logic [4:0] OFS_BAUD  = 5'h10;

	// serial_ctl_one fields.
	localparam int C1_CHAR9 = 0;
	localparam int C1_WAKEA = 1;
	localparam int C1_TX9   = 2;
	localparam int C1_RX9   = 3;
	// serial_ctl_two fields.
	localparam int C2_SBK   = 0;
	localparam int C2_RWU   = 1;
	localparam int C2_RXEN  = 2;
	localparam int C2_TXEN  = 3;
	localparam int C2_QIE   = 4;
	localparam int C2_RIE   = 5;
	localparam int C2_TXDONE_IRQ_EN  = 6;
	localparam int C2_TIE   = 7;
	localparam logic [7:0] CTL2_RST = 8'h00;
	// serial_flags fields.
	localparam int F_FE   = 1;
	localparam int F_NF   = 2;
	localparam int F_OR   = 3;
	localparam int F_QT   = 4;
	localparam int F_RX_BUFFER_FULL = 5;
	localparam int F_TC   = 6;
	localparam int F_TX_BUFFER_EMPTY = 7;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {TX_OFF, TX_IDLE, TX_SHIFT} astr_tx_t;
	typedef enum logic {RX_WAIT, RX_BITS} astr_rx_t;

endpackage : astr_pkg

// >>> logic/astr_uart.sv
`timescale 1ns/100ps
module astr_uart
	import astr_pkg::*;
(
	input  wire logic        core_clk_i,
	input  wire logic        arst_n_i,
	input  wire logic [4:0]  s_axi_awaddr_i,
	input  wire logic        s_axi_awvalid_i,
	output logic             s_axi_awready_o,
	input  wire logic [31:0] s_axi_wdata_i,
	input  wire logic [3:0]  s_axi_wstrb_i,
	input  wire logic        s_axi_wvalid_i,
	output logic             s_axi_wready_o,
	output logic [1:0]       s_axi_bresp_o,
	output logic             s_axi_bvalid_o,
	input  wire logic        s_axi_bready_i,
	input  wire logic [4:0]  s_axi_araddr_i,
	input  wire logic        s_axi_arvalid_i,
	output logic             s_axi_arready_o,
	output logic [31:0]      s_axi_rdata_o,
	output logic [1:0]       s_axi_rresp_o,
	output logic             s_axi_rvalid_o,
	input  wire logic        s_axi_rready_i,
	input  wire logic        rx_pin_i,
	output logic             tx_pin_o,
	output logic             tx_pin_oe_o,
	output logic             irq_o
);

	function automatic logic astr_mapped(input logic [4:0] a);
		return a == OFS_DATA || a == OFS_CTL1 || a == OFS_CTL2 || a == OFS_FLAGS || a == OFS_BAUD;
	endfunction : astr_mapped

	logic        rx_meta, rx_s;
	logic [15:0] baud_div, baud_cnt;
	logic        tick;
	logic        aw_hold, w_hold, next_aw_hold, next_w_hold, wr_fire, rd_fire;
	logic [4:0]  aw_addr;
	logic [31:0] w_data;
	logic [3:0]  w_strb;
	logic        char9, wake_addr, tx_ninth_bit, rx_ninth_bit;
	logic [7:0]  ctl2;
	logic        data_wr, data_rd, stat_rd;
	logic [7:0]  tx_buf, rx_data;
	logic        tx_buffer_empty, tx_done, rx_buffer_full, line_quiet_flag;
	logic        rx_overrun, noise_flag, frame_err;
	logic        arm_tx_buffer_empty, arm_tc, arm_rx_buffer_full, arm_qt, arm_or, arm_nf, arm_fe;
	astr_tx_t    tx_state;
	logic [10:0] tx_sh;
	logic [3:0]  tx_bits, tx_sub, frame_len;
	logic        tx_pre_pend, tx_brk_char, te_d, tc_cond, tc_cond_d;
	logic        tx_slot, load_data;
	astr_rx_t    rx_state;
	logic [3:0]  rx_sub, rx_bit;
	logic [2:0]  rx_smp;
	logic [8:0]  rx_sh;
	logic        rx_noise, rx_maj, rx_done, rx_wake, quiet_hit, quiet_armed;
	logic [7:0]  quiet_cnt;

	wire send_break  = ctl2[C2_SBK];
	wire rx_standby  = ctl2[C2_RWU];
	wire rx_enable   = ctl2[C2_RXEN];
	wire tx_enable   = ctl2[C2_TXEN];
	assign frame_len = char9 ? FRAME9 : FRAME8;

	// ****************************************
	// Receive line synchroniser and baud tick
	// ****************************************
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rx_meta <= 1'b1;
			rx_s    <= 1'b1;
		end else begin
			rx_meta <= rx_pin_i;
			rx_s    <= rx_meta;
		end
	end

	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			baud_cnt <= BAUD_DIV_RST;
			tick     <= 1'b0;
		end else if (baud_cnt == 16'h0000) begin
			baud_cnt <= baud_div;
			tick     <= 1'b1;
		end else begin
			baud_cnt <= baud_cnt - 16'h0001;
			tick     <= 1'b0;
		end
	end

	// ****************************************
	// AXI4-Lite slave
	// ****************************************
	assign wr_fire = aw_hold && w_hold && !s_axi_bvalid_o;
	assign rd_fire = s_axi_arvalid_i && s_axi_arready_o;
	always_comb begin
		next_aw_hold = aw_hold ? !wr_fire : (s_axi_awvalid_i && s_axi_awready_o);
		next_w_hold  = w_hold ? !wr_fire : (s_axi_wvalid_i && s_axi_wready_o);
	end

	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			aw_hold         <= 1'b0;
			w_hold          <= 1'b0;
			s_axi_awready_o <= 1'b1;
			s_axi_wready_o  <= 1'b1;
			aw_addr         <= 5'h00;
			w_data          <= 32'h0000_0000;
			w_strb          <= 4'h0;
			s_axi_bvalid_o  <= 1'b0;
			s_axi_bresp_o   <= RESP_OKAY;
		end else begin
			aw_hold         <= next_aw_hold;
			w_hold          <= next_w_hold;
			s_axi_awready_o <= !next_aw_hold;
			s_axi_wready_o  <= !next_w_hold;
			if (s_axi_awvalid_i && s_axi_awready_o)
				aw_addr <= s_axi_awaddr_i;
			if (s_axi_wvalid_i && s_axi_wready_o) begin
				w_data <= s_axi_wdata_i;
				w_strb <= s_axi_wstrb_i;
			end
			if (wr_fire) begin
				s_axi_bvalid_o <= 1'b1;
				s_axi_bresp_o  <= astr_mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bready_i) begin
				s_axi_bvalid_o <= 1'b0;
			end
		end
	end

	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			s_axi_arready_o <= 1'b1;
			s_axi_rvalid_o  <= 1'b0;
			s_axi_rdata_o   <= 32'h0000_0000;
			s_axi_rresp_o   <= RESP_OKAY;
		end else if (rd_fire) begin
			s_axi_arready_o <= 1'b0;
			s_axi_rvalid_o  <= 1'b1;
			s_axi_rresp_o   <= astr_mapped(s_axi_araddr_i) ? RESP_OKAY : RESP_SLVERR;
			case (s_axi_araddr_i)
				OFS_DATA:  s_axi_rdata_o <= {24'h000000, rx_data};
				OFS_CTL1:  s_axi_rdata_o <= {28'h0000000, rx_ninth_bit, tx_ninth_bit, wake_addr, char9};
				OFS_CTL2:  s_axi_rdata_o <= {24'h000000, ctl2};
				OFS_FLAGS: s_axi_rdata_o <= {24'h000000, tx_buffer_empty, tx_done, rx_buffer_full,
					line_quiet_flag, rx_overrun, noise_flag, frame_err, 1'b0};
				OFS_BAUD:  s_axi_rdata_o <= {16'h0000, baud_div};
				default:   s_axi_rdata_o <= 32'h0000_0000;
			endcase
		end else if (s_axi_rvalid_o && s_axi_rready_i) begin
			s_axi_rvalid_o  <= 1'b0;
			s_axi_arready_o <= 1'b1;
		end
	end

	assign data_wr = wr_fire && aw_addr == OFS_DATA && w_strb[0];
	assign data_rd = rd_fire && s_axi_araddr_i == OFS_DATA;
	assign stat_rd = rd_fire && s_axi_araddr_i == OFS_FLAGS;

	// ****************************************
	// Control registers
	// ****************************************
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ctl2     <= CTL2_RST;
			baud_div <= BAUD_DIV_RST;
		end else begin
			// A software write to the standby bit takes precedence over a wakeup.
			if (wr_fire && aw_addr == OFS_CTL2 && w_strb[0])
				ctl2 <= w_data[7:0];
			else if (rx_wake)
				ctl2[C2_RWU] <= 1'b0;
			if (wr_fire && aw_addr == OFS_BAUD) begin
				if (w_strb[0])
					baud_div[7:0] <= w_data[7:0];
				if (w_strb[1])
					baud_div[15:8] <= w_data[15:8];
			end
		end
	end

	// Reset clears these bits so that every run starts from known values.
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			char9        <= 1'b0;
			wake_addr    <= 1'b0;
			tx_ninth_bit <= 1'b0;
			tx_buf       <= 8'h00;
		end else begin
			if (wr_fire && aw_addr == OFS_CTL1 && w_strb[0]) begin
				char9        <= w_data[C1_CHAR9];
				wake_addr    <= w_data[C1_WAKEA];
				tx_ninth_bit <= w_data[C1_TX9];
			end
			if (data_wr)
				tx_buf <= w_data[7:0];
		end
	end

	// ****************************************
	// Transmitter
	// ****************************************
	// Leaving the off state waits one clock after an enable, so that the preamble request is
	// already pending and buffered data can never overtake it.
	assign tx_slot   = (tx_state == TX_SHIFT) ? (tick && tx_sub == SUB_LAST && tx_bits == 4'h1)
		: (tx_state == TX_IDLE || (tx_enable && te_d));
	assign load_data = tx_slot && !send_break && !tx_brk_char && !tx_pre_pend && !tx_buffer_empty;

	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			tx_state    <= TX_OFF;
			tx_sh       <= 11'h7ff;
			tx_bits     <= 4'h0;
			tx_sub      <= 4'h0;
			tx_pre_pend <= 1'b0;
			tx_brk_char <= 1'b0;
			te_d        <= 1'b0;
		end else begin
			te_d <= tx_enable;
			if (tx_state == TX_SHIFT && tick) begin
				tx_sub <= tx_sub + 4'h1;
				if (tx_sub == SUB_LAST) begin
					tx_sh   <= {1'b1, tx_sh[10:1]};
					tx_bits <= tx_bits - 4'h1;
				end
			end
			if (tx_slot) begin
				tx_sub <= 4'h0;
				if (send_break) begin
					tx_sh       <= 11'h000;
					tx_bits     <= frame_len;
					tx_brk_char <= 1'b1;
					tx_state    <= TX_SHIFT;
				end else if (tx_brk_char) begin
					tx_sh       <= 11'h7ff;
					tx_bits     <= 4'h1;
					tx_brk_char <= 1'b0;
					tx_state    <= TX_SHIFT;
				end else if (tx_pre_pend) begin
					tx_sh       <= 11'h7ff;
					tx_bits     <= frame_len;
					tx_pre_pend <= 1'b0;
					tx_state    <= TX_SHIFT;
				end else if (!tx_buffer_empty) begin
					// Leftover pending data still goes out after a disable.
					tx_sh    <= {1'b1, char9 ? tx_ninth_bit : 1'b1, tx_buf, 1'b0};
					tx_bits  <= frame_len;
					tx_state <= TX_SHIFT;
				end else if (tx_enable) begin
					tx_state <= TX_IDLE;
				end else begin
					tx_state <= TX_OFF;
				end
			end
			if (tx_enable && !te_d)
				tx_pre_pend <= 1'b1;
		end
	end

	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			tx_pin_o    <= 1'b1;
			tx_pin_oe_o <= 1'b0;
		end else begin
			tx_pin_o    <= (tx_state == TX_SHIFT) ? tx_sh[0] : 1'b1;
			tx_pin_oe_o <= tx_state != TX_OFF;
		end
	end

	assign tc_cond = tx_buffer_empty && tx_state != TX_SHIFT && !tx_pre_pend && !send_break
		&& !tx_brk_char;

	// ****************************************
	// Receiver
	// ****************************************
	assign rx_maj  = (rx_smp[0] & rx_smp[1]) | (rx_smp[0] & rx_smp[2]) | (rx_smp[1] & rx_smp[2]);
	assign rx_done = rx_state == RX_BITS && tick && rx_sub == SMP_DECIDE && rx_bit == frame_len - 4'h1;
	assign quiet_hit = rx_state == RX_WAIT && rx_enable
		&& quiet_cnt == (char9 ? QUIET_TICK9 : QUIET_TICK8) && tick && rx_s;
	assign rx_wake = rx_standby && ((rx_done && wake_addr && rx_sh[8])
		|| (quiet_hit && !wake_addr));

	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rx_state  <= RX_WAIT;
			rx_sub    <= 4'h0;
			rx_bit    <= 4'h0;
			rx_smp    <= 3'h7;
			rx_sh     <= 9'h000;
			rx_noise  <= 1'b0;
			quiet_cnt <= 8'h00;
		end else if (!rx_enable) begin
			rx_state  <= RX_WAIT;
			quiet_cnt <= 8'h00;
		end else if (tick) begin
			case (rx_state)
				RX_WAIT: begin
					if (!rx_s) begin
						rx_state  <= RX_BITS;
						rx_sub    <= 4'h1;
						rx_bit    <= 4'h0;
						rx_noise  <= 1'b0;
						quiet_cnt <= 8'h00;
					end else if (quiet_cnt != (char9 ? QUIET_TICK9 : QUIET_TICK8)) begin
						quiet_cnt <= quiet_cnt + 8'h01;
					end
				end
				RX_BITS: begin
					rx_sub <= rx_sub + 4'h1;
					if (rx_sub == SMP_FIRST)
						rx_smp[0] <= rx_s;
					if (rx_sub == SMP_MID)
						rx_smp[1] <= rx_s;
					if (rx_sub == SMP_LAST)
						rx_smp[2] <= rx_s;
					if (rx_sub == SMP_DECIDE) begin
						if (!(&rx_smp) && (|rx_smp))
							rx_noise <= 1'b1;
						if (rx_bit == 4'h0 && rx_maj)
							rx_state <= RX_WAIT;
						else if (rx_bit == frame_len - 4'h1)
							rx_state <= RX_WAIT;
						else if (rx_bit != 4'h0)
							rx_sh <= {rx_maj, rx_sh[8:1]};
						rx_bit <= rx_bit + 4'h1;
					end
				end
				default: rx_state <= RX_WAIT;
			endcase
		end
	end

	// ****************************************
	// Status flags and clearing sequences
	// ****************************************
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			{arm_tx_buffer_empty, arm_tc, arm_rx_buffer_full, arm_qt, arm_or, arm_nf, arm_fe} <= 7'h00;
		end else if (stat_rd) begin
			{arm_tx_buffer_empty, arm_tc, arm_rx_buffer_full, arm_qt, arm_or, arm_nf, arm_fe} <= {tx_buffer_empty,
				tx_done, rx_buffer_full, line_quiet_flag, rx_overrun, noise_flag, frame_err};
		end else begin
			if (data_wr)
				{arm_tx_buffer_empty, arm_tc} <= 2'h0;
			if (data_rd)
				{arm_rx_buffer_full, arm_qt, arm_or, arm_nf, arm_fe} <= 5'h00;
		end
	end

	// Hardware sets win over a clearing access in the same cycle.
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			tx_buffer_empty <= 1'b1;
			tx_done         <= 1'b1;
			tc_cond_d       <= 1'b1;
		end else begin
			tc_cond_d <= tc_cond;
			if (load_data)
				tx_buffer_empty <= 1'b1;
			else if (data_wr && arm_tx_buffer_empty)
				tx_buffer_empty <= 1'b0;
			if (tc_cond && !tc_cond_d)
				tx_done <= 1'b1;
			else if (data_wr && arm_tc)
				tx_done <= 1'b0;
		end
	end

	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rx_buffer_full  <= 1'b0;
			rx_overrun      <= 1'b0;
			noise_flag      <= 1'b0;
			frame_err       <= 1'b0;
			line_quiet_flag <= 1'b0;
			quiet_armed     <= 1'b0;
			rx_data         <= 8'h00;
			rx_ninth_bit    <= 1'b0;
		end else begin
			if (data_rd && arm_rx_buffer_full)
				rx_buffer_full <= 1'b0;
			if (data_rd && arm_or)
				rx_overrun <= 1'b0;
			if (data_rd && arm_nf)
				noise_flag <= 1'b0;
			if (data_rd && arm_fe)
				frame_err <= 1'b0;
			if (data_rd && arm_qt)
				line_quiet_flag <= 1'b0;
			// Characters heard in standby are dropped unless address-mark wakeup is selected and they carry the mark.
			if (rx_done && (!rx_standby || rx_wake)) begin
				if (rx_buffer_full && !(data_rd && arm_rx_buffer_full)) begin
					rx_overrun <= 1'b1;
				end else begin
					rx_buffer_full <= 1'b1;
					rx_data        <= char9 ? rx_sh[7:0] : rx_sh[8:1];
					rx_ninth_bit   <= rx_sh[8];
					noise_flag     <= rx_noise;
					frame_err      <= !rx_maj;
				end
			end
			if (rx_state == RX_BITS)
				quiet_armed <= 1'b1;
			if (quiet_hit && quiet_armed) begin
				line_quiet_flag <= 1'b1;
				quiet_armed     <= 1'b0;
			end
		end
	end

	// ****************************************
	// Shared interrupt request
	// ****************************************
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i)
			irq_o <= 1'b0;
		else
			irq_o <= (tx_buffer_empty && ctl2[C2_TIE])
				|| (tx_done && ctl2[C2_TXDONE_IRQ_EN])
				|| (rx_enable && !rx_standby
				&& (((rx_buffer_full || rx_overrun) && ctl2[C2_RIE])
				|| (line_quiet_flag && ctl2[C2_QIE])));
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!arst_n_i);

	a_tx_buffer_empty_on_load: assert property (load_data |=> tx_buffer_empty)
		else $error("tx_buffer_empty not set on buffer load");
	a_start_stop: assert property (load_data |=> tx_sh[0] == 1'b0 && tx_sh[10] == 1'b1)
		else $error("frame lacks start or stop bit");
	a_pin_release: assert property ($fell(tx_pin_oe_o) |-> $past(tx_buffer_empty, 2))
		else $error("pin released with data pending");
	a_break_low: assert property (tx_state == TX_SHIFT && tx_brk_char |=> !tx_pin_o)
		else $error("break character drives high");
	a_fe_with_full: assert property ($rose(frame_err) |->
		rx_buffer_full && $past(rx_done))
		else $error("frame_err set apart from rx_buffer_full");
	a_nf_with_full: assert property ($rose(noise_flag) |->
		rx_buffer_full && $past(rx_done))
		else $error("noise_flag set apart from rx_buffer_full");
	a_overrun_cause: assert property ($rose(rx_overrun) |-> $past(rx_buffer_full))
		else $error("overrun without a full buffer");
	a_standby_quiet: assert property (rx_standby && !$past(rx_standby) && !(tx_buffer_empty
		&& ctl2[C2_TIE]) && !(tx_done && ctl2[C2_TXDONE_IRQ_EN]) |=> !irq_o)
		else $error("receiver request in standby");
	a_tx_buffer_empty_irq_mask: assert property (tx_buffer_empty && ctl2[C2_TIE] |=> irq_o)
		else $error("masked-in tx_buffer_empty gives no request");
	a_tc_meaning: assert property ($rose(tx_done) |->
		$past(tx_buffer_empty) && $past(tx_state) != TX_SHIFT)
		else $error("tx_done while still sending");

	c_data_sent:  cover property (load_data ##[1:300] tx_done);
	c_break_end:  cover property ($fell(send_break) ##[1:1000] tx_state == TX_IDLE);
	c_rx_char:    cover property ($rose(rx_buffer_full));
	c_idle_wake:  cover property (rx_wake && !wake_addr);

endmodule : astr_uart

// >>> test/astr_remote.sv
`timescale 1ns/100ps
// ****************
// Remote serial device
// ****************
module astr_remote (
	input  wire logic       core_clk_i,
	input  wire logic       tx_line_i,
	output logic            rx_line_o,
	output logic [8:0]      got_o,
	output int              got_cnt_o
);
	int noise_bit = -1;

	initial rx_line_o = 1'h1;

	// The divisor is zero, so one bit lasts sixteen clocks.
	task automatic send(input logic [8:0] d, input int nbits, input logic stop);
		@(posedge core_clk_i) rx_line_o <= 1'h0;
		repeat (16) @(posedge core_clk_i);
		for (int i = 0; i < nbits; i++) begin
			rx_line_o <= d[i];
			if (i == noise_bit) begin
				// One inverted clock lands on the first of the three samples.
				repeat (7) @(posedge core_clk_i);
				rx_line_o <= ~d[i];
				@(posedge core_clk_i);
				rx_line_o <= d[i];
				repeat (8) @(posedge core_clk_i);
			end else begin
				repeat (16) @(posedge core_clk_i);
			end
		end
		rx_line_o <= stop;
		repeat (16) @(posedge core_clk_i);
		rx_line_o <= 1'h1;
	endtask : send

	// Samples mid-bit; got_o[8] holds the stop bit of an 8-bit frame (the ninth bit of a 9-bit one), so a wrong stop shows.
	initial begin
		got_cnt_o = 0;
		forever begin
			@(negedge tx_line_i);
			repeat (8) @(posedge core_clk_i);
			for (int i = 0; i < 9; i++) begin
				repeat (16) @(posedge core_clk_i);
				got_o[i] = tx_line_i;
			end
			got_cnt_o++;
		end
	end
endmodule : astr_remote

// >>> test/tb_astr_uart.sv
`timescale 1ns/100ps
// ****************
// Bench for the serial block
// ****************
module tb_astr_uart import astr_pkg::*;;
	logic clk = 1'h0, rst_n = 1'h0, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
	logic arvalid = 1'h0, rready = 1'h0;
	logic [4:0] awaddr = 5'h0, araddr = 5'h0;
	logic [31:0] wdata = 32'h0, rdata, d;
	logic [1:0] bresp, rresp, resp;
	logic awready, wready, bvalid, arready, rvalid, tx_pin, tx_oe, irq, rx_line;
	logic [8:0] got;
	logic [7:0] ctl [3] = '{8'h88, 8'h48, 8'h08};
	int got_cnt, failures = 0, compares = 0, cyc = 0;
	// The released pin is pulled up.
	wire tx_line = tx_oe ? tx_pin : 1'h1;

	astr_uart uut (.core_clk_i(clk), .arst_n_i(rst_n), .s_axi_awaddr_i(awaddr),
		.s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
		.s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
		.s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
		.s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
		.s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
		.s_axi_rready_i(rready), .rx_pin_i(rx_line), .tx_pin_o(tx_pin),
		.tx_pin_oe_o(tx_oe), .irq_o(irq));
	astr_remote rem (.core_clk_i(clk), .tx_line_i(tx_line), .rx_line_o(rx_line),
		.got_o(got), .got_cnt_o(got_cnt));

	always #12.5 clk = ~clk;

	task automatic wr(input logic [4:0] a, input logic [31:0] v);
		@(posedge clk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		do begin
			@(posedge clk);
			if (awready) awvalid <= 1'h0;
			if (wready) wvalid <= 1'h0;
		end while (!bvalid);
		bready <= 1'h0;
		resp = bresp;
	endtask : wr

	task automatic rd(input logic [4:0] a, output logic [31:0] v);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do begin
			@(posedge clk);
			if (arready) arvalid <= 1'h0;
		end while (!rvalid);
		rready <= 1'h0;
		v = rdata;
		resp = rresp;
	endtask : rd

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic conclude();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : conclude

	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			failures++;
			conclude();
		end
	end

	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1'h1;
		rd(OFS_FLAGS, d);
		chk("flags", d, 32'hc0);
		rd(5'h14, d);
		chk("resp", 32'(resp), 32'(RESP_SLVERR));
		wr(OFS_BAUD, 32'h0);
		wr(OFS_CTL2, 32'h8);
		repeat (4) @(posedge clk);
		chk("oe", 32'(tx_oe), 32'h1);
		rd(OFS_FLAGS, d);
		wr(OFS_DATA, 32'ha5);
		repeat (80) @(posedge clk);
		rd(OFS_FLAGS, d);
		chk("flags", d, 32'h0);
		wait (got_cnt == 1);
		chk("tx char", 32'(got), 32'h1a5);
		repeat (20) @(posedge clk);
		rd(OFS_FLAGS, d);
		chk("flags", d, 32'hc0);
		for (int i = 0; i < 3; i++) begin
			wr(OFS_CTL2, {24'h0, ctl[i]});
			repeat (2) @(posedge clk);
			chk("irq", 32'(irq), 32'(ctl[i][7:6] != 2'h0));
		end
		// Disabling while a byte is still being shifted out must not cut it off.
		rd(OFS_FLAGS, d);
		wr(OFS_DATA, 32'h5a);
		wr(OFS_CTL2, 32'h0);
		wait (got_cnt == 2);
		chk("tx char", 32'(got), 32'h15a);
		repeat (20) @(posedge clk);
		chk("oe", 32'(tx_oe), 32'h0);
		wr(OFS_CTL2, 32'h24);
		rem.send(9'h3c, 8, 1'h1);
		repeat (4) @(posedge clk);
		chk("irq", 32'(irq), 32'h1);
		rd(OFS_FLAGS, d);
		chk("flags", d, 32'he0);
		rd(OFS_DATA, d);
		chk("data", d, 32'h3c);
		rd(OFS_FLAGS, d);
		chk("flags", d, 32'hc0);
		rem.send(9'h11, 8, 1'h1);
		rem.send(9'h22, 8, 1'h1);
		rd(OFS_FLAGS, d);
		chk("flags", d, 32'he8);
		rd(OFS_DATA, d);
		chk("data", d, 32'h11);
		repeat (200) @(posedge clk);
		rd(OFS_FLAGS, d);
		chk("flags", d, 32'hd0);
		rd(OFS_DATA, d);
		rem.send(9'h55, 8, 1'h0);
		rd(OFS_FLAGS, d);
		chk("flags", d, 32'he2);
		rd(OFS_DATA, d);
		wr(OFS_CTL1, 32'h1);
		rem.send(9'h1a5, 9, 1'h1);
		rd(OFS_CTL1, d);
		chk("ninth", d, 32'h9);
		rd(OFS_DATA, d);
		chk("data", d, 32'ha5);
		rd(OFS_FLAGS, d);
		chk("flags", d, 32'he0);
		rd(OFS_DATA, d);
		rem.noise_bit = 2;
		rem.send(9'h0f3, 9, 1'h1);
		rem.noise_bit = -1;
		rd(OFS_FLAGS, d);
		chk("flags", d, 32'he4);
		rd(OFS_DATA, d);
		chk("data", d, 32'hf3);
		// Standby with address-mark wakeup: an unmarked character is dropped.
		wr(OFS_CTL1, 32'h3);
		wr(OFS_CTL2, 32'h26);
		rem.send(9'h0aa, 9, 1'h1);
		rd(OFS_FLAGS, d);
		chk("flags", d, 32'hc0);
		rem.send(9'h1aa, 9, 1'h1);
		rd(OFS_CTL2, d);
		chk("ctl2", d, 32'h24);
		chk("irq", 32'(irq), 32'h1);
		wr(OFS_CTL2, 32'h26);
		repeat (2) @(posedge clk);
		chk("irq", 32'(irq), 32'h0);
		rd(OFS_FLAGS, d);
		chk("flags", d, 32'he0);
		rd(OFS_DATA, d);
		chk("data", d, 32'haa);
		wr(OFS_CTL1, 32'h1);
		repeat (200) @(posedge clk);
		rd(OFS_CTL2, d);
		chk("ctl2", d, 32'h24);
		// Break from a fresh enable, then data in 9-bit mode with the ninth bit set.
		wr(OFS_CTL1, 32'h5);
		rd(OFS_FLAGS, d);
		wr(OFS_CTL2, 32'h9);
		wait (got_cnt == 3);
		chk("break", 32'(got), 32'h0);
		wr(OFS_CTL2, 32'h8);
		wr(OFS_DATA, 32'h3c);
		wait (got_cnt == 4);
		chk("tx char", 32'(got), 32'h13c);
		conclude();
	end
endmodule : tb_astr_uart
